/* verilog/bsfe_pkg.sv */
// ==========================================================
// board io select and fpu error constants
package bsfe_pkg;
	// ==========================================================
	// register byte addresses
	localparam logic [7:0]  OFS_RANGE      = 8'h00;
	localparam logic [7:0]  OFS_PERIPH_EN  = 8'h04;
	localparam logic [7:0]  OFS_STATUS     = 8'h08;
	localparam logic [7:0]  OFS_COPRO_ERR  = 8'hf0;
	// ==========================================================
	// field positions
	localparam int          RANGE_BASE_LSB = 0;
	localparam int          RANGE_MASK_LSB = 16;
	localparam int          EN_FPU_ERR_BIT = 0;
	localparam int          EN_ALT_A20_BIT = 1;
	localparam int          ST_FAULT_BIT   = 0;
	localparam int          ST_IGNORE_BIT  = 1;
	localparam int          ST_DIV3_BIT    = 2;
	// ==========================================================
	// values after reset
	localparam logic [31:0] RANGE_RESET    = 32'h0000_0000;
	localparam logic [1:0]  PERIPH_RESET   = 2'h0;
	// strobes, fault and strap idle high, so no false edge follows reset
	localparam logic [9:0]  PIN_IDLE       = 10'h3c5;
	// ==========================================================
	// decode values
	localparam logic [12:0] KBC_PORT_HI    = 13'h000c;
	localparam logic [12:0] CLK_PORT_HI    = 13'h000e;
	localparam logic [1:0]  BOOT_ROM_TOP   = 2'h3;
	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS  = 10;
	localparam logic [2:0]  DIV_SLOW       = 3'h4;
	localparam logic [2:0]  DIV_FAST       = 3'h3;
	localparam logic [2:0]  CLK_HIGH_CNT   = 3'h2;
	localparam logic [1:0]  LATCH_PERIODS  = 2'h2;
	typedef enum logic [1:0] {
		LATCH_IDLE = 2'b00,
		LATCH_HOLD = 2'b01
	} bsfe_latch_e;
endpackage

/* verilog/bsfe_sync.sv */
`timescale 1ns/10ps
// ==========================================================
// two flip-flop synchroniser, one per bit
module bsfe_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	if (WIDTH < 1) begin : g_chk
		$error("bsfe_sync width must be at least one");
	end
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_reg;
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				meta_reg    <= RESET_VAL[i];
				sync_out[i] <= RESET_VAL[i];
			end else begin
				meta_reg    <= async_in[i];
				sync_out[i] <= meta_reg;
			end
		end
	end
endmodule

/* verilog/bsfe_top.sv */
`timescale 1ns/10ps
// Operation
// - programmable select only for ranged master io
// - buffer enable follows any of the four selects
// - boot rom select on rom range access
// - no boot rom select during dma
// - keypad select on ports 60h-66h even
// - no keypad select during dma
// - clock chip select on ports 71h-77h odd
// - latch pulse on writes to 70h-76h even
// - latch starts at write fall, two periods
// - tone output follows timer counter two
// - timer tick taken from oscillator input
// - enabled fault raises fpu interrupt line
// - error handling only while enable set
// - error port write with fault asserts ignore
// - ignore held until fault negates
// - no ignore without an active fault
// - bus clock is system clock by three/four
module bsfe_top
	import bsfe_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic [ADDR_W-1:0] ext_addr_lines,
	input  wire logic              io_write_strobe_n,
	input  wire logic              io_read_strobe_n,
	input  wire logic              mem_read_strobe_n,
	input  wire logic              mem_write_strobe_n,
	input  wire logic              dma_cycle,
	input  wire logic              sys_master_cycle,
	input  wire logic              timer_cnt2_out,
	input  wire logic              timer_ref_in,
	input  wire logic              fpu_fault_n,
	input  wire logic              power_good,
	input  wire logic              ext_clk_strap_in,
	output logic                   programmable_select_n,
	output logic                   ext_buf_en,
	output logic                   boot_rom_select_n,
	output logic                   keypad_ctrl_select_n,
	output logic                   clock_chip_select_n,
	output logic                   clock_chip_addr_latch,
	output logic                   tone_out,
	output logic                   timer_ref_tick,
	output logic                   fpu_irq_line,
	output logic                   fpu_ignore_fault_n_out,
	output logic                   fpu_ignore_fault_oe,
	output logic                   alt_addr_bit20_mask,
	output logic                   ext_bus_clock
);
	if (ADDR_W != 18) begin : g_chk
		$error("bsfe_top decodes exactly eighteen address lines");
	end
	// ==========================================================
	// pin synchronisers
	localparam int SW = ADDR_W + 10;
	logic [SW-1:0]     sync_vec;
	logic [ADDR_W-1:0] addr_s;
	logic              iow_n_s, ior_n_s, memr_n_s, memw_n_s, dma_s, mst_s;
	logic              tref_s, fault_n_s, pgood_s, strap_s;
	bsfe_sync #(.WIDTH(SW), .RESET_VAL({{ADDR_W{1'b0}}, PIN_IDLE})) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in ({ext_addr_lines, io_write_strobe_n, io_read_strobe_n, mem_read_strobe_n,
		            mem_write_strobe_n, dma_cycle, sys_master_cycle, timer_ref_in, fpu_fault_n,
		            power_good, ext_clk_strap_in}),
		.sync_out (sync_vec)
	);
	assign {addr_s, iow_n_s, ior_n_s, memr_n_s, memw_n_s, dma_s, mst_s,
	        tref_s, fault_n_s, pgood_s, strap_s} = sync_vec;
	// ==========================================================
	// ahb-lite slave, zero wait states, always okay
	logic [31:0] range_reg;
	logic [1:0]  periph_enable_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        ignore_reg;
	logic        div3_reg;
	logic        fault_s;
	logic        err_en;
	logic        ahb_go;
	logic [31:0] rd_next;
	logic        copro_wr;
	assign fault_s  = !fault_n_s;
	assign err_en   = periph_enable_reg[EN_FPU_ERR_BIT];
	assign ahb_go   = hsel && htrans[1] && hready;
	assign copro_wr = wr_pend_reg && (wr_addr_reg == OFS_COPRO_ERR);
	always_comb begin
		rd_next = 32'h0000_0000;
		if (haddr[7:0] == OFS_RANGE) begin
			rd_next = range_reg;
		end else if (haddr[7:0] == OFS_PERIPH_EN) begin
			rd_next = {30'h0000_0000, periph_enable_reg};
		end else if (haddr[7:0] == OFS_STATUS) begin
			rd_next[ST_FAULT_BIT]  = fault_s;
			rd_next[ST_IGNORE_BIT] = ignore_reg;
			rd_next[ST_DIV3_BIT]   = div3_reg;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata      <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= ahb_go && hwrite;
			if (ahb_go) begin
				wr_addr_reg <= haddr[7:0];
			end
			if (ahb_go && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
				hrdata <= rd_next;
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			range_reg         <= RANGE_RESET;
			periph_enable_reg <= PERIPH_RESET;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == OFS_RANGE) begin
				range_reg <= hwdata;
			end else if (wr_addr_reg == OFS_PERIPH_EN) begin
				periph_enable_reg <= hwdata[1:0];
			end
		end
	end
	// ==========================================================
	// chip select decode, registered so pins come from flops
	logic io_cyc, mem_cyc, psel_hit, kbc_hit, clk_hit, rom_hit, ale_port;
	logic [15:0] rng_base, rng_mask;
	assign rng_base = range_reg[RANGE_BASE_LSB +: 16];
	assign rng_mask = range_reg[RANGE_MASK_LSB +: 16];
	assign io_cyc   = !iow_n_s || !ior_n_s;
	assign mem_cyc  = !memr_n_s || !memw_n_s;
	assign psel_hit = io_cyc && mst_s && !dma_s && (((addr_s[15:0] ^ rng_base) & ~rng_mask) == 16'h0000);
	assign kbc_hit  = io_cyc && !dma_s && (addr_s[15:3] == KBC_PORT_HI) && !addr_s[0];
	assign clk_hit  = io_cyc && (addr_s[15:3] == CLK_PORT_HI) && addr_s[0];
	assign rom_hit  = mem_cyc && !dma_s && (addr_s[17:16] == BOOT_ROM_TOP);
	assign ale_port = (addr_s[15:3] == CLK_PORT_HI) && !addr_s[0];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			programmable_select_n <= 1'b1;
			ext_buf_en            <= 1'b0;
			keypad_ctrl_select_n  <= 1'b1;
			clock_chip_select_n   <= 1'b1;
			boot_rom_select_n     <= 1'b1;
		end else begin
			programmable_select_n <= !psel_hit;
			ext_buf_en            <= psel_hit || kbc_hit || clk_hit || rom_hit;
			keypad_ctrl_select_n  <= !kbc_hit;
			clock_chip_select_n   <= !clk_hit;
			boot_rom_select_n     <= !rom_hit;
		end
	end
	// ==========================================================
	// bus clock divider, divisor strapped at power good rise
	logic       pgood_d_reg;
	logic [2:0] div_cnt_reg;
	logic [2:0] div_max;
	logic       ext_rise;
	assign div_max  = div3_reg ? DIV_FAST : DIV_SLOW;
	assign ext_rise = (div_cnt_reg == 3'h0);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pgood_d_reg <= 1'b0;
			div3_reg    <= 1'b0;
		end else begin
			pgood_d_reg <= pgood_s;
			if (pgood_s && !pgood_d_reg) begin
				div3_reg <= !strap_s;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_reg   <= 3'h0;
			ext_bus_clock <= 1'b0;
		end else begin
			div_cnt_reg   <= (div_cnt_reg >= div_max - 3'h1) ? 3'h0 : div_cnt_reg + 3'h1;
			ext_bus_clock <= (div_cnt_reg < CLK_HIGH_CNT);
		end
	end
	// ==========================================================
	// clock chip address latch pulse
	bsfe_latch_e latch_state_reg;
	logic        iow_d_reg;
	logic [1:0]  per_cnt_reg;
	logic        iow_fall;
	assign iow_fall = iow_d_reg && !iow_n_s;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iow_d_reg             <= 1'b1;
			latch_state_reg       <= LATCH_IDLE;
			per_cnt_reg           <= 2'h0;
			clock_chip_addr_latch <= 1'b1;
		end else begin
			iow_d_reg <= iow_n_s;
			case (latch_state_reg)
				LATCH_IDLE: begin
					clock_chip_addr_latch <= 1'b0;
					if (iow_fall && ale_port) begin
						latch_state_reg       <= LATCH_HOLD;
						per_cnt_reg           <= 2'h0;
						clock_chip_addr_latch <= 1'b1;
					end
				end
				LATCH_HOLD: begin
					// counts bus clock rises, so the pulse spans two full periods at either divisor
					if (ext_rise) begin
						per_cnt_reg <= per_cnt_reg + 2'h1;
					end
					if (ext_rise && (per_cnt_reg == LATCH_PERIODS)) begin
						latch_state_reg       <= LATCH_IDLE;
						clock_chip_addr_latch <= 1'b0;
					end
				end
				default: begin
					latch_state_reg       <= LATCH_IDLE;
					clock_chip_addr_latch <= 1'b0;
				end
			endcase
		end
	end
	// ==========================================================
	// tone, timer reference, a20 mask
	logic tref_d_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tone_out            <= 1'b0;
			tref_d_reg          <= 1'b0;
			timer_ref_tick      <= 1'b0;
			alt_addr_bit20_mask <= 1'b0;
		end else begin
			tone_out            <= timer_cnt2_out;
			tref_d_reg          <= tref_s;
			timer_ref_tick      <= tref_s && !tref_d_reg;
			alt_addr_bit20_mask <= periph_enable_reg[EN_ALT_A20_BIT];
		end
	end
	// ==========================================================
	// coprocessor error handshake
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ignore_reg             <= 1'b0;
			fpu_irq_line           <= 1'b0;
			fpu_ignore_fault_oe    <= 1'b0;
			fpu_ignore_fault_n_out <= 1'b0;
		end else begin
			if (!err_en || !fault_s) begin
				ignore_reg <= 1'b0;
			end else if (copro_wr) begin
				ignore_reg <= 1'b1;
			end
			fpu_irq_line           <= err_en && fault_s;
			fpu_ignore_fault_oe    <= ignore_reg && err_en && fault_s;
			fpu_ignore_fault_n_out <= 1'b0;
		end
	end
	// ==========================================================
	// assertions
	property p_psel_master;
		@(posedge hclk) disable iff (!hresetn) !programmable_select_n |-> $past(mst_s) && !$past(dma_s);
	endproperty
	a_psel_master: assert property (p_psel_master) else $error("programmable select without master io");
	property p_buf_en;
		@(posedge hclk) disable iff (!hresetn) !programmable_select_n |-> ext_buf_en;
	endproperty
	a_buf_en: assert property (p_buf_en) else $error("buffer not enabled with select");
	property p_rom_dma;
		@(posedge hclk) disable iff (!hresetn) $past(dma_s) |-> boot_rom_select_n;
	endproperty
	a_rom_dma: assert property (p_rom_dma) else $error("boot rom select in dma");
	property p_kbc_hit;
		@(posedge hclk) disable iff (!hresetn)
			(io_cyc && !dma_s && addr_s[15:0] == 16'h0064) |=> !keypad_ctrl_select_n;
	endproperty
	a_kbc_hit: assert property (p_kbc_hit) else $error("keypad select missed");
	property p_kbc_dma;
		@(posedge hclk) disable iff (!hresetn) !keypad_ctrl_select_n |-> !$past(dma_s);
	endproperty
	a_kbc_dma: assert property (p_kbc_dma) else $error("keypad select in dma");
	property p_latch_len;
		@(posedge hclk) disable iff (!hresetn) $rose(clock_chip_addr_latch) |-> clock_chip_addr_latch [*6];
	endproperty
	a_latch_len: assert property (p_latch_len) else $error("latch pulse too short");
	property p_latch_start;
		@(posedge hclk) disable iff (!hresetn)
			(latch_state_reg == LATCH_IDLE && iow_fall && ale_port) |=> clock_chip_addr_latch;
	endproperty
	a_latch_start: assert property (p_latch_start) else $error("latch did not start");
	property p_tone;
		@(posedge hclk) disable iff (!hresetn) ##1 tone_out == $past(timer_cnt2_out);
	endproperty
	a_tone: assert property (p_tone) else $error("tone not following counter");
	property p_irq;
		@(posedge hclk) disable iff (!hresetn) fpu_irq_line |-> $past(err_en) && $past(fault_s);
	endproperty
	a_irq: assert property (p_irq) else $error("fpu irq without enabled fault");
	property p_ign_set;
		@(posedge hclk) disable iff (!hresetn)
			(copro_wr && err_en && fault_s) ##1 (err_en && fault_s) |=> fpu_ignore_fault_oe;
	endproperty
	a_ign_set: assert property (p_ign_set) else $error("ignore not asserted");
	property p_ign_fault;
		@(posedge hclk) disable iff (!hresetn) fpu_ignore_fault_oe |-> $past(fault_s) && $past(err_en);
	endproperty
	a_ign_fault: assert property (p_ign_fault) else $error("ignore without fault");
	property p_ign_release;
		@(posedge hclk) disable iff (!hresetn) (ignore_reg && !fault_s) |=> !fpu_ignore_fault_oe;
	endproperty
	a_ign_release: assert property (p_ign_release) else $error("ignore not released");
	property p_div;
		@(posedge hclk) disable iff (!hresetn) $rose(ext_bus_clock) |-> ##[3:4] $rose(ext_bus_clock);
	endproperty
	a_div: assert property (p_div) else $error("bus clock period wrong");
endmodule

/* test/bsfe_peer.sv */
`timescale 1ns/10ps
// ==========================================================
// far side: ext bus cycles, oscillator, cpu fault and a20 pins
module bsfe_peer (
	input  wire logic        hclk,
	input  wire logic        fpu_ignore_fault_oe,
	input  wire logic        fpu_ignore_fault_n_out,
	input  wire logic        alt_addr_bit20_mask,
	output logic [17:0]      ext_addr_lines,
	output logic             io_write_strobe_n,
	output logic             io_read_strobe_n,
	output logic             mem_read_strobe_n,
	output logic             mem_write_strobe_n,
	output logic             dma_cycle,
	output logic             sys_master_cycle,
	output logic             timer_ref_in,
	output logic             fpu_fault_n,
	output logic             fpu_ignore_fault_n,
	output logic             cpu_addr_wrap_mask_n
);
	logic [3:0] stb_n;
	logic       kbc_a20_gate;
	assign {mem_write_strobe_n, mem_read_strobe_n, io_write_strobe_n, io_read_strobe_n} = stb_n;
	// open drain, pulled up whenever released
	assign fpu_ignore_fault_n = fpu_ignore_fault_oe ? fpu_ignore_fault_n_out : 1'b1;
	assign cpu_addr_wrap_mask_n = ~(alt_addr_bit20_mask | kbc_a20_gate);
	// oscillator runs free, unrelated to hclk
	initial begin
		stb_n = 4'hf;
		ext_addr_lines = 18'h0;
		dma_cycle = 1'b0;
		sys_master_cycle = 1'b0;
		fpu_fault_n = 1'b1;
		kbc_a20_gate = 1'b0;
		timer_ref_in = 1'b0;
		forever #34.92 timer_ref_in = ~timer_ref_in;
	end
	// kind: 0 io read, 1 io write, 2 mem read, 3 mem write
	task automatic bus_start(input logic [1:0] k, input logic [17:0] a, input logic dma, input logic mst);
		ext_addr_lines <= a;
		dma_cycle <= dma;
		sys_master_cycle <= mst;
		@(posedge hclk);
		stb_n[k] <= 1'b0;
	endtask
	// address lines keep the stale value one cycle after the strobes rise, then show the inverse
	task automatic bus_end();
		stb_n <= 4'hf;
		@(posedge hclk);
		ext_addr_lines <= ~ext_addr_lines;
		dma_cycle <= 1'b0;
		sys_master_cycle <= 1'b0;
		@(posedge hclk);
	endtask
	task automatic set_fault(input logic f);
		fpu_fault_n <= ~f;
	endtask
endmodule

/* test/bsfe_top_test.sv */
`timescale 1ns/10ps
// ==========================================================
// self-checking bench
module bsfe_top_test
	import bsfe_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, d, r;
	logic [1:0]  htrans, h;
	logic [2:0]  hsize;
	logic [17:0] ext_addr_lines, a;
	logic        io_write_strobe_n, io_read_strobe_n, mem_read_strobe_n, mem_write_strobe_n;
	logic        dma_cycle, sys_master_cycle, timer_cnt2_out, timer_ref_in, fpu_fault_n, power_good;
	logic        ext_clk_strap_in, programmable_select_n, ext_buf_en, boot_rom_select_n, keypad_ctrl_select_n;
	logic        clock_chip_select_n, clock_chip_addr_latch, tone_out, timer_ref_tick, fpu_irq_line;
	logic        fpu_ignore_fault_n_out, fpu_ignore_fault_oe, alt_addr_bit20_mask, ext_bus_clock;
	logic        fpu_ignore_fault_n, cpu_addr_wrap_mask_n, t;
	logic [15:0] base, mask;
	logic [3:0]  sel_now;
	logic [17:0] kp [14] = '{18'h60, 18'h62, 18'h64, 18'h66, 18'h61, 18'h68, 18'h6e, 18'h71, 18'h73, 18'h75,
		18'h77, 18'h70, 18'h79, 18'h0};
	int          n_errors, checked, seed, i, p, osc_n, tick_n;
	assign sel_now = {~programmable_select_n, ~boot_rom_select_n, ~keypad_ctrl_select_n, ~clock_chip_select_n};
	bsfe_top #(.ADDR_W(18)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .ext_addr_lines, .io_write_strobe_n, .io_read_strobe_n,
		.mem_read_strobe_n, .mem_write_strobe_n, .dma_cycle, .sys_master_cycle, .timer_cnt2_out, .timer_ref_in,
		.fpu_fault_n, .power_good, .ext_clk_strap_in, .programmable_select_n, .ext_buf_en, .boot_rom_select_n,
		.keypad_ctrl_select_n, .clock_chip_select_n, .clock_chip_addr_latch, .tone_out, .timer_ref_tick,
		.fpu_irq_line, .fpu_ignore_fault_n_out, .fpu_ignore_fault_oe, .alt_addr_bit20_mask, .ext_bus_clock);
	bsfe_peer peer (.hclk, .fpu_ignore_fault_oe, .fpu_ignore_fault_n_out, .alt_addr_bit20_mask, .ext_addr_lines,
		.io_write_strobe_n, .io_read_strobe_n, .mem_read_strobe_n, .mem_write_strobe_n, .dma_cycle,
		.sys_master_cycle, .timer_ref_in, .fpu_fault_n, .fpu_ignore_fault_n, .cpu_addr_wrap_mask_n);
	initial begin
		hclk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) hclk = ~hclk;
	end
	always @(posedge timer_ref_in) osc_n++;
	always @(posedge hclk) if (timer_ref_tick === 1'b1) tick_n++;
	// ==========================================================
	// checks and bus tasks
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp, input string what);
		cmp32({31'h0, got}, {31'h0, exp}, what);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] rd);
		haddr <= ad;
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic rd_cmp(input logic [31:0] ad, input logic [31:0] exp, input string what);
		logic [31:0] v;
		ahb(1'b0, ad, 32'h0, v);
		cmp32(v, exp, what);
		cmp1(hresp, 1'b0, "okay response");
	endtask
	function automatic logic [3:0] exp_sel(input logic [1:0] k, input logic [17:0] ad, input logic dma,
		input logic mst);
		logic        io;
		logic [15:0] q;
		io = (k < 2'h2);
		q = ad[15:0];
		exp_sel[3] = io && mst && !dma && (((q ^ base) & ~mask) == 16'h0);
		exp_sel[2] = !io && (ad[17:16] == 2'h3) && !dma;
		exp_sel[1] = io && !dma && (q inside {16'h60, 16'h62, 16'h64, 16'h66});
		exp_sel[0] = io && (q inside {16'h71, 16'h73, 16'h75, 16'h77});
	endfunction
	task automatic ext_check(input logic [1:0] k, input logic [17:0] ad, input logic dma, input logic mst);
		logic [3:0] e;
		e = exp_sel(k, ad, dma, mst);
		peer.bus_start(k, ad, dma, mst);
		repeat (5) @(posedge hclk);
		cmp32({28'h0, sel_now}, {28'h0, e}, "selects");
		cmp1(ext_buf_en, |e, "buffer enable");
		peer.bus_end();
		repeat (5) @(posedge hclk);
		cmp32({27'h0, ext_buf_en, sel_now}, 32'h0, "selects idle");
	endtask
	task automatic latch_check(input logic [17:0] ad, input logic hit);
		int first, cnt, j;
		first = -1;
		cnt = 0;
		peer.bus_start(2'h1, ad, 1'b0, 1'b1);
		for (j = 0; j < 30; j++) begin
			@(posedge hclk);
			if (clock_chip_addr_latch === 1'b1) begin
				cnt++;
				if (first < 0) first = j;
			end
		end
		peer.bus_end();
		cmp1(hit ? first inside {[1:6]} : cnt == 0, 1'b1, "latch start");
		cmp1(hit ? cnt inside {[6:13]} : cnt == 0, 1'b1, "latch width");
	endtask
	task automatic bus_period(output int n);
		logic last;
		repeat (2) begin
			n = 0;
			do begin
				last = ext_bus_clock;
				@(posedge hclk);
				n++;
			end while (!(last === 1'b0 && ext_bus_clock === 1'b1) && n < 20);
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h93f6;
		{n_errors, checked, osc_n, tick_n} = '0;
		{hresetn, haddr, htrans, hwrite, hwdata, timer_cnt2_out, power_good, base, mask, h, t} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		ext_clk_strap_in = 1'b1;
		repeat (4) @(posedge hclk);
		cmp32(32'({clock_chip_addr_latch, tone_out, alt_addr_bit20_mask, fpu_ignore_fault_oe}), 32'h8, "reset");
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_cmp({24'h0, OFS_RANGE}, RANGE_RESET, "range reset");
		rd_cmp({24'h0, OFS_COPRO_ERR}, 32'h0, "error port write only");
		rd_cmp(32'h40, 32'h0, "unmapped");
		bus_period(p);
		cmp32(p, 32'd4, "bus clock div4");
		foreach (kp[i]) ext_check(2'h0, kp[i], 1'b0, 1'b1);
		ext_check(2'h1, 18'h64, 1'b1, 1'b0);
		ext_check(2'h0, 18'h75, 1'b1, 1'b0);
		ext_check(2'h2, 18'h30000, 1'b0, 1'b0);
		ext_check(2'h3, 18'h3ffff, 1'b0, 1'b0);
		ext_check(2'h2, 18'h2ffff, 1'b0, 1'b0);
		ext_check(2'h2, 18'h31234, 1'b1, 1'b0);
		ext_check(2'h0, 18'h0, 1'b0, 1'b0);
		ext_check(2'h0, 18'h0, 1'b1, 1'b1);
		r = $random(seed);
		base = r[15:0];
		mask = r[31:16] & 16'h00ff;
		ahb(1'b1, {24'h0, OFS_RANGE}, {mask, base}, d);
		for (i = 0; i < 24; i++) begin
			r = $random(seed);
			a = r[3] ? {r[17:16], r[31:16]} : {2'h0, r[1] ? base ^ (r[31:16] & mask) : r[31:16]};
			ext_check(r[3:2], a, r[5:4] == 2'h0, r[6]);
		end
		foreach (kp[i]) if (i >= 7) latch_check(kp[i], kp[i] inside {18'h70, 18'h72, 18'h74, 18'h76});
		latch_check(18'h76, 1'b1);
		osc_n = 0;
		tick_n = 0;
		for (i = 0; i < 200; i++) begin
			@(posedge hclk);
			cmp1(tone_out, h[0], "tone");
			h = {h[0], t};
			t = 1'($random(seed));
			timer_cnt2_out <= t;
		end
		cmp1((osc_n - tick_n) inside {[-2:2]}, 1'b1, "osc ticks");
		ahb(1'b1, {24'h0, OFS_PERIPH_EN}, 32'h1, d);
		peer.set_fault(1'b1);
		repeat (6) @(posedge hclk);
		cmp1(fpu_irq_line, 1'b1, "irq");
		cmp1(fpu_ignore_fault_n, 1'b1, "ignore before write");
		ahb(1'b1, {24'h0, OFS_COPRO_ERR}, $random(seed), d);
		repeat (3) @(posedge hclk);
		cmp1(fpu_ignore_fault_n, 1'b0, "ignore set");
		repeat (20) @(posedge hclk);
		cmp1(fpu_ignore_fault_n, 1'b0, "ignore held");
		peer.set_fault(1'b0);
		repeat (6) @(posedge hclk);
		cmp32(32'({fpu_irq_line, fpu_ignore_fault_n}), 32'h1, "fault gone");
		ahb(1'b1, {24'h0, OFS_COPRO_ERR}, 32'hffffffff, d);
		repeat (6) @(posedge hclk);
		cmp1(fpu_ignore_fault_n, 1'b1, "no fault write");
		ahb(1'b1, {24'h0, OFS_STATUS}, 32'hffffffff, d);
		rd_cmp({24'h0, OFS_STATUS}, 32'h0, "status read only");
		// reporting off: fault and port write must both be ignored
		ahb(1'b1, {24'h0, OFS_PERIPH_EN}, 32'h2, d);
		peer.set_fault(1'b1);
		ahb(1'b1, {24'h0, OFS_COPRO_ERR}, 32'h0, d);
		repeat (6) @(posedge hclk);
		cmp32(32'({fpu_irq_line, fpu_ignore_fault_n}), 32'h1, "disabled");
		cmp32(32'({alt_addr_bit20_mask, cpu_addr_wrap_mask_n}), 32'h2, "a20 mask");
		rd_cmp({24'h0, OFS_PERIPH_EN}, 32'h2, "enable readback");
		peer.set_fault(1'b0);
		ext_clk_strap_in <= 1'b0;
		power_good <= 1'b1;
		repeat (8) @(posedge hclk);
		ext_clk_strap_in <= 1'b1;
		bus_period(p);
		cmp32(p, 32'd3, "bus clock div3");
		final_report();
	end
	// run needs about 1200 cycles
	initial begin
		repeat (6000) @(posedge hclk);
		n_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		final_report();
	end
endmodule
